// >>> hw/axis_counter_consts.vh
`ifndef AXIS_COUNTER_CONSTS_VH
`define AXIS_COUNTER_CONSTS_VH

// Register byte addresses
`define ADDR_SIGNAL_MODE 6'h00
`define ADDR_INPUT_ENV 6'h04
`define ADDR_CLEAR_CFG 6'h08
`define ADDR_LATCH_ENV 6'h0c
`define ADDR_IRQ_ENABLE 6'h10
`define ADDR_IRQ_CAUSE 6'h14
`define ADDR_ERROR_CAUSE 6'h18
`define ADDR_PIN_STATE 6'h1c
`define ADDR_COMMAND 6'h20
`define ADDR_COUNTER1 6'h24
`define ADDR_COUNTER2 6'h28
`define ADDR_COUNTER3 6'h2c
`define ADDR_COUNTER4 6'h30

// Field positions
`define CLR_MODE_LO 20
`define PINF_BIT 19
`define PIM_LO 24
`define PULSER_COUNT_DIRECTION_BIT 26
`define PDIS_BIT 27
`define ERRSENSE_BIT 28
`define CLR_SEL_LO 16
`define HOME_SEL_LO 20
`define LATCH_SEL_LO 24
`define CLR_EVT_BIT 13
`define ENC_ERR_BIT 16
`define PUL_ERR_BIT 17

// Decode and trigger modes
`define PIM_1X 2'h0
`define PIM_2X 2'h1
`define PIM_4X 2'h2
`define PIM_TWO 2'h3
`define CLR_FALL 2'h0
`define CLR_RISE 2'h1
`define CLR_LOW 2'h2
`define CLR_HIGH 2'h3

// Commands, widths, timing
`define CMD_ZERO_BASE 8'h20
`define FILT_CYCLES 2'h3
`define CNT_MASK_WIDE 28'hfffffff
`define CNT_MASK_NARROW 28'h000ffff
`define RESET_WORD 32'h00000000

`endif

// >>> hw/axis_counter_input_and_reset.v
`timescale 1ns/1ps
`include "axis_counter_consts.vh"

module axis_counter_input_and_reset (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Avalon-MM slave
  input wire [5:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  output reg [31:0] readdata_o,
  output wire waitrequest_o,
  // Phase and clear pins
  input wire pulser_phase_a_i,
  input wire pulser_phase_b_i,
  input wire encoder_phase_a_i,
  input wire encoder_phase_b_i,
  input wire counter_clear_input_i,
  // Same-clock axis events
  input wire cmd_step_i,
  input wire cmd_dir_i,
  input wire homing_done_i,
  input wire latch_event_i,
  // Interrupt
  output reg irq_n_o
);

  integer i;

  ////////////////////////////////////////////////////////////////////////////
  // All five pins are asynchronous to the reference clock.
  // Two stages keep metastability away from the filter and decoder.
  // Latency cost is two clocks on every pin, harmless at pulser rates.
  // Synchronisers: stage one is read only by stage two
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end else begin
      sync1_reg <= {counter_clear_input_i, encoder_phase_b_i,
                    encoder_phase_a_i, pulser_phase_b_i, pulser_phase_a_i};
      sync2_reg <= sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  reg [31:0] signal_mode_reg;
  reg [31:0] input_env_reg;
  reg [31:0] clear_cfg_reg;
  reg [31:0] latch_env_reg;
  reg [31:0] irq_enable_reg;
  reg [31:0] irq_cause_reg;
  reg [31:0] error_cause_reg;
  reg ack_reg;

  wire [1:0] pim = input_env_reg[`PIM_LO+1:`PIM_LO];
  wire pulser_count_direction = input_env_reg[`PULSER_COUNT_DIRECTION_BIT];
  wire pdis = input_env_reg[`PDIS_BIT];
  wire pinf = input_env_reg[`PINF_BIT];
  wire errsense = input_env_reg[`ERRSENSE_BIT];
  wire [1:0] clr_mode = signal_mode_reg[`CLR_MODE_LO+1:`CLR_MODE_LO];
  wire [3:0] clr_sel = clear_cfg_reg[`CLR_SEL_LO+3:`CLR_SEL_LO];
  wire [3:0] home_sel = clear_cfg_reg[`HOME_SEL_LO+3:`HOME_SEL_LO];
  wire [3:0] latch_sel = latch_env_reg[`LATCH_SEL_LO+3:`LATCH_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // One counter per phase, restarted whenever the pin returns.
  // A level is only taken after it has stood for the full count.
  // With the filter off the synchronised level passes straight on.
  // Adds two clocks of delay on a clean edge.
  // Pulser glitch filter: change must persist 3 clocks before it is taken
  reg [1:0] filt_reg;
  reg [1:0] filt_cnt_reg [0:1];
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      filt_reg <= 2'h0;
      for (i = 0; i < 2; i = i + 1)
        filt_cnt_reg[i] <= 2'h0;
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (!pinf) begin
          filt_reg[i] <= sync2_reg[i];
          filt_cnt_reg[i] <= 2'h0;
        end else if (sync2_reg[i] == filt_reg[i]) begin
          filt_cnt_reg[i] <= 2'h0;
        end else if (filt_cnt_reg[i] == `FILT_CYCLES - 2'h1) begin
          filt_reg[i] <= sync2_reg[i];
          filt_cnt_reg[i] <= 2'h0;
        end else begin
          filt_cnt_reg[i] <= filt_cnt_reg[i] + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Previous levels give edge detection on both phases.
  // Reset value zero matches the idle pin level, so no false edge.
  // Encoder phases feed only the simultaneous-change sensing here.
  // Counting the encoder is done by neighbouring logic.
  // Pulser decoder
  reg [1:0] pul_prev_reg;
  reg [1:0] enc_prev_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pul_prev_reg <= 2'h0;
      enc_prev_reg <= 2'h0;
    end else begin
      pul_prev_reg <= filt_reg;
      enc_prev_reg <= sync2_reg[3:2];
    end
  end

  // Swapping phases turns B-leading into forward
  wire pa = pulser_count_direction ? filt_reg[1] : filt_reg[0];
  wire pb = pulser_count_direction ? filt_reg[0] : filt_reg[1];
  wire pa_prev = pulser_count_direction ? pul_prev_reg[1] : pul_prev_reg[0];
  wire pb_prev = pulser_count_direction ? pul_prev_reg[0] : pul_prev_reg[1];
  wire da = pa ^ pa_prev;
  wire db = pb ^ pb_prev;
  wire both_pul = da & db;
  wire both_enc = &(sync2_reg[3:2] ^ enc_prev_reg);

  reg pul_up;
  reg pul_dn;
  // Simultaneous change is ambiguous, so it never counts
  always @* begin
    pul_up = 1'b0;
    pul_dn = 1'b0;
    case (pim)
      `PIM_1X: begin
        pul_up = da & pa & ~pb;
        pul_dn = da & ~pa & ~pb;
      end
      `PIM_2X: begin
        pul_up = da & (pa ^ pb);
        pul_dn = da & ~(pa ^ pb);
      end
      `PIM_4X: begin
        pul_up = (da & (pa ^ pb)) | (db & ~(pa ^ pb));
        pul_dn = (da & ~(pa ^ pb)) | (db & (pa ^ pb));
      end
      `PIM_TWO: begin
        pul_up = da & pa;
        pul_dn = db & pb;
      end
      default: begin
        pul_up = 1'b0;
        pul_dn = 1'b0;
      end
    endcase
    if (pdis || both_pul) begin
      pul_up = 1'b0;
      pul_dn = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge modes fire for one clock, level modes for as long as held.
  // A held level zeroes the selected counters on every clock that brings no count.
  // Changing the mode while the pin is active may fire once at once.
  // Clear input trigger
  reg clr_prev_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      clr_prev_reg <= 1'b0;
    else
      clr_prev_reg <= sync2_reg[4];
  end

  wire clr_now = sync2_reg[4];
  reg clr_trig;
  always @* begin
    case (clr_mode)
      `CLR_FALL: clr_trig = clr_prev_reg & ~clr_now;
      `CLR_RISE: clr_trig = ~clr_prev_reg & clr_now;
      `CLR_LOW: clr_trig = ~clr_now;
      `CLR_HIGH: clr_trig = clr_now;
      default: clr_trig = 1'b0;
    endcase
  end
  // Active sense follows the polarity chosen by the mode
  wire clr_active = clr_mode[0] ? clr_now : ~clr_now;

  ////////////////////////////////////////////////////////////////////////////
  // Every access takes exactly one wait state.
  // The acknowledge toggles, so a held request restarts a new access.
  // Masters must release on the edge that sees waitrequest low.
  // Writes take effect on that same edge.
  // Bus decode
  wire req = read_i | write_i;
  wire wr_go = write_i & ack_reg;
  assign waitrequest_o = req & ~ack_reg;

  // One wait state gives a registered read path
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  wire cmd_go = wr_go && (address_i == `ADDR_COMMAND);
  wire [7:0] cmd_code = writedata_i[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Delay lets the latch capture the old value before it is zeroed.
  // Latch-follow reset fires one clock after the latch
  reg latch_dly_reg;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      latch_dly_reg <= 1'b0;
    else
      latch_dly_reg <= latch_event_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // All reset sources are merged per counter before the update.
  // A count in the same clock as a reset is never lost.
  // Counter 1 follows the command step; 2 to 4 follow the pulser.
  // Upper bits of counter 3 are masked so it wraps at 16 bits.
  // Four position counters; counter 3 is 16 bits wide
  reg [27:0] cnt_reg [0:3];
  reg [27:0] cnt_next [0:3];
  reg [3:0] rst_req;
  reg [3:0] cnt_ev;
  reg [3:0] cnt_up;
  reg [27:0] mask;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      rst_req[i] = (clr_trig & clr_sel[i])
        | (homing_done_i & home_sel[i])
        | (latch_dly_reg & latch_sel[i])
        | (cmd_go && cmd_code == `CMD_ZERO_BASE + i[7:0]);
      cnt_ev[i] = (i == 0) ? cmd_step_i : (pul_up | pul_dn);
      cnt_up[i] = (i == 0) ? cmd_dir_i : pul_up;
      mask = (i == 2) ? `CNT_MASK_NARROW : `CNT_MASK_WIDE;
      if (rst_req[i] && cnt_ev[i])
        cnt_next[i] = (cnt_up[i] ? 28'h0000001 : `CNT_MASK_WIDE) & mask;
      else if (rst_req[i])
        cnt_next[i] = 28'h0000000;
      else if (cnt_ev[i] && cnt_up[i])
        cnt_next[i] = (cnt_reg[i] + 28'h0000001) & mask;
      else if (cnt_ev[i])
        cnt_next[i] = (cnt_reg[i] - 28'h0000001) & mask;
      else
        cnt_next[i] = cnt_reg[i];
    end
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < 4; i = i + 1)
        cnt_reg[i] <= 28'h0000000;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        cnt_reg[i] <= cnt_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear event only counts when it actually resets a counter.
  // Pulser errors are not raised while the pulser is disabled.
  // Event sources for the sticky status bits
  wire clr_event = clr_trig & (|clr_sel);
  wire enc_err = errsense & both_enc;
  wire pul_err = errsense & both_pul & ~pdis;

  // Register writes; a new event wins over a write-one clear
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      signal_mode_reg <= `RESET_WORD;
      input_env_reg <= `RESET_WORD;
      clear_cfg_reg <= `RESET_WORD;
      latch_env_reg <= `RESET_WORD;
      irq_enable_reg <= `RESET_WORD;
      irq_cause_reg <= `RESET_WORD;
      error_cause_reg <= `RESET_WORD;
    end else begin
      if (wr_go) begin
        case (address_i)
          `ADDR_SIGNAL_MODE: signal_mode_reg <= writedata_i;
          `ADDR_INPUT_ENV: input_env_reg <= writedata_i;
          `ADDR_CLEAR_CFG: clear_cfg_reg <= writedata_i;
          `ADDR_LATCH_ENV: latch_env_reg <= writedata_i;
          `ADDR_IRQ_ENABLE: irq_enable_reg <= writedata_i;
          `ADDR_IRQ_CAUSE: begin
            irq_cause_reg[`CLR_EVT_BIT] <=
              irq_cause_reg[`CLR_EVT_BIT] & ~writedata_i[`CLR_EVT_BIT];
          end
          `ADDR_ERROR_CAUSE: begin
            error_cause_reg[`ENC_ERR_BIT] <=
              error_cause_reg[`ENC_ERR_BIT] & ~writedata_i[`ENC_ERR_BIT];
            error_cause_reg[`PUL_ERR_BIT] <=
              error_cause_reg[`PUL_ERR_BIT] & ~writedata_i[`PUL_ERR_BIT];
          end
          default: ;
        endcase
      end
      if (clr_event)
        irq_cause_reg[`CLR_EVT_BIT] <= 1'b1;
      if (enc_err)
        error_cause_reg[`ENC_ERR_BIT] <= 1'b1;
      if (pul_err)
        error_cause_reg[`PUL_ERR_BIT] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered read path keeps the long mux off the bus timing.
  // Data stands until the next read captures over it.
  // Unmapped addresses read as zero.
  // Read data, captured in the wait cycle
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = `RESET_WORD;
    case (address_i)
      `ADDR_SIGNAL_MODE: rd_mux = signal_mode_reg;
      `ADDR_INPUT_ENV: rd_mux = input_env_reg;
      `ADDR_CLEAR_CFG: rd_mux = clear_cfg_reg;
      `ADDR_LATCH_ENV: rd_mux = latch_env_reg;
      `ADDR_IRQ_ENABLE: rd_mux = irq_enable_reg;
      `ADDR_IRQ_CAUSE: rd_mux = irq_cause_reg;
      `ADDR_ERROR_CAUSE: rd_mux = error_cause_reg;
      `ADDR_PIN_STATE: rd_mux[`CLR_EVT_BIT] = clr_active;
      `ADDR_COUNTER1: rd_mux = {4'h0, cnt_reg[0]};
      `ADDR_COUNTER2: rd_mux = {4'h0, cnt_reg[1]};
      `ADDR_COUNTER3: rd_mux = {4'h0, cnt_reg[2]};
      `ADDR_COUNTER4: rd_mux = {4'h0, cnt_reg[3]};
      default: rd_mux = `RESET_WORD;
    endcase
  end

  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      readdata_o <= `RESET_WORD;
    else if (read_i && !ack_reg)
      readdata_o <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered output avoids glitches on the shared interrupt line.
  // Clears one clock after software clears the last enabled cause.
  // Active-low interrupt, level while any enabled cause is set
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      irq_n_o <= 1'b1;
    else
      irq_n_o <= ~(|((irq_cause_reg | error_cause_reg)
        & irq_enable_reg));
  end

endmodule

// >>> tb/axis_counter_props.sv
`timescale 1ns/1ps
`include "axis_counter_consts.vh"

module axis_counter_props (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Bus and interrupt
  input wire [5:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] readdata_o,
  input wire waitrequest_o,
  input wire irq_n_o
);
  // Request pending and read completing now
  wire req = read_i | write_i;
  wire rd_ok = read_i & ~waitrequest_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////
  property p_wait; req && waitrequest_o |=> !waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_idle; !req |-> !waitrequest_o; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_ack; req && !waitrequest_o |=> !req || waitrequest_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  // Read data must stand between reads
  property p_stand; !read_i |=> $stable(readdata_o); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_unmap; rd_ok && address_i > `ADDR_COUNTER4 |->
    readdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not zero");
  property p_err; rd_ok && address_i == `ADDR_ERROR_CAUSE |->
    readdata_o[15:0] == 16'h0 && readdata_o[31:18] == 14'h0; endproperty
  a_err: assert property (p_err) else $error("error bits");
  property p_pin; rd_ok && address_i == `ADDR_PIN_STATE |->
    readdata_o[12:0] == 13'h0; endproperty
  a_pin: assert property (p_pin) else $error("pin bits");
  // Only a software write can release the interrupt
  property p_irq; $rose(irq_n_o) |-> $past(write_i) || $past(write_i, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq release");
  c_irq: cover property ($fell(irq_n_o));
  c_rd: cover property (rd_ok && address_i == `ADDR_COUNTER2);
  c_cmd: cover property (write_i && address_i == `ADDR_COMMAND);
endmodule

bind axis_counter_input_and_reset axis_counter_props u_props (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .irq_n_o(irq_n_o));

// >>> tb/pulser_source.sv
`timescale 1ns/1ps

module pulser_source (
  // Clock
  input wire mclk_i,
  // Pulser a b, encoder a b, clear
  output reg [4:0] pins_o
);
  // Pins sit still between calls, like a real hand pulser
  initial pins_o = 5'h0;
  task drv(input [4:0] v, input integer n);
    begin
      @(posedge mclk_i);
      pins_o <= v;
      repeat (n) @(posedge mclk_i);
    end
  endtask
  // One quadrature cycle, A leading
  task quad;
    begin
      drv(5'h10, 6);
      drv(5'h18, 6);
      drv(5'h08, 6);
      drv(5'h00, 8);
    end
  endtask
endmodule

// >>> tb/axis_counter_input_and_reset_tb.sv
`timescale 1ns/1ps
`include "axis_counter_consts.vh"

module axis_counter_input_and_reset_tb;
  reg mclk_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [5:0] address_i = 6'h0;
  reg read_i = 1'b0;
  reg write_i = 1'b0;
  reg [31:0] writedata_i = 32'h0;
  reg [3:0] ev = 4'h0;
  reg [31:0] r;
  reg [31:0] e;
  wire [31:0] readdata_o;
  wire waitrequest_o;
  wire irq_n_o;
  wire [4:0] pins;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i;

  always #2 mclk_i = ~mclk_i;
  pulser_source u_src (.mclk_i(mclk_i), .pins_o(pins));
  axis_counter_input_and_reset u_dut (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .pulser_phase_a_i(pins[4]), .pulser_phase_b_i(pins[3]),
    .encoder_phase_a_i(pins[2]), .encoder_phase_b_i(pins[1]),
    .counter_clear_input_i(pins[0]), .cmd_step_i(ev[3]),
    .cmd_dir_i(ev[2]), .homing_done_i(ev[1]), .latch_event_i(ev[0]),
    .irq_n_o(irq_n_o));
  //////////////////////////////
  task test_done;
    begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task bus(input w, input [5:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge mclk_i);
      address_i <= a;
      writedata_i <= d;
      write_i <= w;
      read_i <= !w;
      t = 0;
      @(posedge mclk_i);
      while (waitrequest_o !== 1'b0 && t < 100) begin
        t = t + 1;
        @(posedge mclk_i);
      end
      if (waitrequest_o !== 1'b0) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t bus hang", $time);
        test_done;
      end
      r = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rc(input [5:0] a, input [31:0] x);
    begin
      bus(1'b0, a, 32'h0);
      chk(r, x);
    end
  endtask
  // Step, direction, homing, latch; room left for the latch reset
  task pulse(input [3:0] v);
    begin
      @(posedge mclk_i);
      ev <= v;
      @(posedge mclk_i);
      ev <= 4'h0;
      repeat (3) @(posedge mclk_i);
    end
  endtask
  task irq(input v);
    begin
      repeat (3) @(posedge mclk_i);
      chk({31'h0, irq_n_o}, {31'h0, v});
    end
  endtask
  //////////////////////////////
  task t_zero;
    begin
      rc(6'h3c, 32'h0);
      wr(`ADDR_INPUT_ENV, 32'h03000000);
      repeat (3) pulse(4'hc);
      u_src.drv(5'h10, 6);
      u_src.drv(5'h00, 8);
      for (i = 0; i < 4; i = i + 1) begin
        rc(6'h24 + {i[3:0], 2'b00}, i == 0 ? 32'h3 : 32'h1);
        wr(`ADDR_COMMAND, 32'h20 + i);
        rc(6'h24 + {i[3:0], 2'b00}, 32'h0);
      end
    end
  endtask
  task t_quad;
    for (i = 0; i < 6; i = i + 1) begin
      wr(`ADDR_INPUT_ENV, ((i / 3) << 26) | ((i % 3) << 24));
      wr(`ADDR_COMMAND, 32'h21);
      u_src.quad;
      e = (i % 3 == 2) ? 32'h4 : i % 3 + 1;
      rc(`ADDR_COUNTER2, i < 3 ? e : 32'h10000000 - e);
    end
  endtask
  // Two-cycle pulse is the longest that must be dropped
  task t_filter;
    begin
      wr(`ADDR_INPUT_ENV, 32'h03080000);
      wr(`ADDR_COMMAND, 32'h21);
      u_src.drv(5'h10, 1);
      u_src.drv(5'h00, 8);
      rc(`ADDR_COUNTER2, 32'h0);
      u_src.drv(5'h10, 6);
      u_src.drv(5'h00, 8);
      rc(`ADDR_COUNTER2, 32'h1);
      wr(`ADDR_INPUT_ENV, 32'h0b000000);
      u_src.drv(5'h10, 6);
      u_src.drv(5'h00, 8);
      rc(`ADDR_COUNTER2, 32'h1);
    end
  endtask
  task t_clear;
    begin
      wr(`ADDR_CLEAR_CFG, 32'h000f0000);
      wr(`ADDR_SIGNAL_MODE, 32'h00100000);
      wr(`ADDR_IRQ_ENABLE, 32'h00002000);
      pulse(4'hc);
      irq(1'b1);
      u_src.drv(5'h01, 8);
      irq(1'b0);
      rc(`ADDR_COUNTER1, 32'h0);
      rc(`ADDR_IRQ_CAUSE, 32'h2000);
      rc(`ADDR_PIN_STATE, 32'h2000);
      u_src.drv(5'h00, 8);
      rc(`ADDR_PIN_STATE, 32'h0);
      wr(`ADDR_IRQ_CAUSE, 32'h2000);
      irq(1'b1);
      wr(`ADDR_SIGNAL_MODE, 32'h0);
      rc(`ADDR_PIN_STATE, 32'h2000);
      pulse(4'hc);
      u_src.drv(5'h01, 8);
      rc(`ADDR_COUNTER1, 32'h1);
      u_src.drv(5'h00, 8);
      rc(`ADDR_COUNTER1, 32'h0);
      wr(`ADDR_CLEAR_CFG, 32'h0);
      wr(`ADDR_IRQ_ENABLE, 32'h0);
    end
  endtask
  task t_err;
    begin
      wr(`ADDR_INPUT_ENV, 32'h10000000);
      u_src.drv(5'h18, 8);
      u_src.drv(5'h1e, 8);
      irq(1'b1);
      rc(`ADDR_ERROR_CAUSE, 32'h00030000);
      wr(`ADDR_IRQ_ENABLE, 32'h00030000);
      irq(1'b0);
      u_src.drv(5'h00, 8);
      wr(`ADDR_ERROR_CAUSE, 32'h00030000);
      irq(1'b1);
      rc(`ADDR_ERROR_CAUSE, 32'h0);
    end
  endtask
  task t_home;
    begin
      wr(`ADDR_CLEAR_CFG, 32'h00100000);
      wr(`ADDR_LATCH_ENV, 32'h01000000);
      pulse(4'hc);
      pulse(4'h2);
      rc(`ADDR_COUNTER1, 32'h0);
      pulse(4'hc);
      pulse(4'h1);
      rc(`ADDR_COUNTER1, 32'h0);
      pulse(4'he);
      rc(`ADDR_COUNTER1, 32'h1);
      pulse(4'ha);
      rc(`ADDR_COUNTER1, 32'h0fffffff);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_zero;
    t_quad;
    t_filter;
    t_clear;
    t_err;
    t_home;
    test_done;
  end
endmodule
